//--- rtl/eudc_pkg.sv
package eudc_pkg;
  localparam int NUM_CNT = 8;
  localparam int DATA_W = 32;
  localparam int STAMP_W = 64;
  localparam int ADDR_W = 12;
  localparam int STRB_W = 4;
  localparam logic [31:0] COUNT_MAX = 32'h7fff_ffff;
  localparam logic [31:0] COUNT_MIN = 32'h8000_0000;
  localparam logic [31:0] COUNT_ONE = 32'h0000_0001;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] PRESET_RST = 32'h0000_0000;
  localparam logic [31:0] COMPARE_RST = 32'h0000_0000;
  localparam logic [5:0] OFF_CTRL = 6'h00;
  localparam logic [5:0] OFF_PRESET = 6'h04;
  localparam logic [5:0] OFF_COMPARE = 6'h08;
  localparam logic [5:0] OFF_COUNT = 6'h0c;
  localparam logic [5:0] OFF_FROZEN = 6'h10;
  localparam logic [5:0] OFF_STAMP_LO = 6'h14;
  localparam logic [5:0] OFF_STAMP_HI = 6'h18;
  localparam logic [5:0] OFF_STATUS = 6'h1c;
  localparam logic [5:0] OFF_NV_COUNT = 6'h20;
  localparam logic [5:0] OFF_NV_FROZEN = 6'h24;
  localparam int SEL_LSB = 6;
  localparam int SEL_W = 3;
  localparam int MAP_LSB = 9;
  localparam int CTRL_EN_BIT = 0;
  localparam int STAT_ABOVE_BIT = 0;
  localparam int STAT_EQUAL_BIT = 1;
  localparam int STAT_BELOW_BIT = 2;
  localparam int STAT_BLOCKED_BIT = 3;
  localparam int STAT_NV_BIT = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- rtl/eudc_counter_bank.sv
`timescale 1ns/1ps
module eudc_counter_bank (
  // Clock, reset and clock enable.
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite write channels.
  input wire logic [eudc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [eudc_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [eudc_pkg::STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels.
  input wire logic [eudc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [eudc_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Logic operands driving the counters, one bit per counter.
  input wire logic [eudc_pkg::NUM_CNT-1:0] count_up,
  input wire logic [eudc_pkg::NUM_CNT-1:0] count_down,
  input wire logic [eudc_pkg::NUM_CNT-1:0] count_block,
  input wire logic [eudc_pkg::NUM_CNT-1:0] load_preset_select,
  input wire logic [eudc_pkg::NUM_CNT-1:0] count_reset,
  input wire logic [eudc_pkg::NUM_CNT-1:0] freeze_reset,
  input wire logic [eudc_pkg::NUM_CNT-1:0] freeze_count,
  // Date and time, and control power loss warning.
  input wire logic [eudc_pkg::STAMP_W-1:0] stamp_time,
  input wire logic power_fail,
  // Counter output operands.
  output logic [eudc_pkg::NUM_CNT-1:0] count_above_flag,
  output logic [eudc_pkg::NUM_CNT-1:0] count_equal_flag,
  output logic [eudc_pkg::NUM_CNT-1:0] count_below_flag,
  output logic nv_saved
);

  localparam int N = eudc_pkg::NUM_CNT;

  logic [31:0] ctrl [N];
  logic [31:0] preset [N];
  logic [31:0] compare [N];
  logic signed [31:0] count [N];
  logic signed [31:0] frozen [N];
  logic [63:0] stamp [N];
  logic [31:0] nv_count [N];
  logic [31:0] nv_frozen [N];
  logic signed [31:0] next_count [N];
  logic [N-1:0] capture;
  logic [N-1:0] en;
  logic [N-1:0] en_d;
  logic [N-1:0] up_d;
  logic [N-1:0] dn_d;
  logic [N-1:0] lps_d;
  logic [N-1:0] rst_d;
  logic [N-1:0] frr_d;
  logic [N-1:0] frc_d;
  logic [N-1:0] up_rise;
  logic [N-1:0] dn_rise;
  logic [N-1:0] lps_rise;
  logic [N-1:0] rst_rise;
  logic [N-1:0] frr_rise;
  logic [N-1:0] frc_rise;
  logic [N-1:0] en_rise;
  logic [N-1:0] running;
  logic pf_d;
  logic aw_held;
  logic w_held;
  logic [eudc_pkg::ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_go;
  logic [31:0] rd_word;
  logic rd_ok;

  function automatic logic [31:0] byte_merge(input logic [31:0] old, input logic [31:0] data,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        res[8*b +: 8] = data[8*b +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic addr_mapped(input logic [eudc_pkg::ADDR_W-1:0] a);
    return a[eudc_pkg::ADDR_W-1:eudc_pkg::MAP_LSB] == '0;
  endfunction

  function automatic logic [eudc_pkg::SEL_W-1:0] addr_sel(input logic [eudc_pkg::ADDR_W-1:0] a);
    return a[eudc_pkg::SEL_LSB +: eudc_pkg::SEL_W];
  endfunction

  // Edge detection against the previous pass value.
  always_comb
  begin
    for (int i = 0; i < N; i++)
    begin
      en[i] = ctrl[i][eudc_pkg::CTRL_EN_BIT];
    end
  end
  assign up_rise = count_up & ~up_d;
  assign dn_rise = count_down & ~dn_d;
  assign lps_rise = load_preset_select & ~lps_d;
  assign rst_rise = count_reset & ~rst_d;
  assign frr_rise = freeze_reset & ~frr_d;
  assign frc_rise = freeze_count & ~frc_d;
  assign en_rise = en & ~en_d;
  assign running = en & en_d;

  // Next count for every counter.
  always_comb
  begin
    for (int i = 0; i < N; i++)
    begin
      next_count[i] = count[i];
      capture[i] = 1'b0;
      if (en_rise[i])
      begin
        next_count[i] = load_preset_select[i] ? preset[i] : eudc_pkg::ZERO_WORD;
      end
      else if (running[i])
      begin
        if (rst_rise[i] || frr_rise[i])
        begin
          next_count[i] = load_preset_select[i] ? preset[i] : eudc_pkg::ZERO_WORD;
          capture[i] = frr_rise[i];
        end
        else
        begin
          capture[i] = frc_rise[i];
          if (lps_rise[i])
          begin
            next_count[i] = preset[i];
          end
          else if (!count_block[i] && (up_rise[i] ^ dn_rise[i]))
          begin
            // Plain 32-bit add and subtract wrap across the signed limits.
            next_count[i] = up_rise[i] ? count[i] + eudc_pkg::COUNT_ONE
                                       : count[i] - eudc_pkg::COUNT_ONE;
          end
        end
      end
    end
  end

  // Counter state, one set per counter.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < N; i++)
      begin
        count[i] <= '0;
        frozen[i] <= '0;
        stamp[i] <= '0;
      end
      en_d <= '0;
      up_d <= '0;
      dn_d <= '0;
      lps_d <= '0;
      rst_d <= '0;
      frr_d <= '0;
      frc_d <= '0;
      count_above_flag <= '0;
      count_equal_flag <= '0;
      count_below_flag <= '0;
    end
    else if (ce)
    begin
      en_d <= en;
      up_d <= count_up;
      dn_d <= count_down;
      lps_d <= load_preset_select;
      rst_d <= count_reset;
      frr_d <= freeze_reset;
      frc_d <= freeze_count;
      for (int i = 0; i < N; i++)
      begin
        count[i] <= next_count[i];
        if (capture[i])
        begin
          frozen[i] <= count[i];
          stamp[i] <= stamp_time;
        end
        if (count_block[i] || !en[i])
        begin
          count_above_flag[i] <= 1'b0;
          count_equal_flag[i] <= 1'b0;
          count_below_flag[i] <= 1'b0;
        end
        else
        begin
          count_above_flag[i] <= next_count[i] > $signed(compare[i]);
          count_equal_flag[i] <= next_count[i] == $signed(compare[i]);
          count_below_flag[i] <= next_count[i] < $signed(compare[i]);
        end
      end
    end
  end

  // Retained copies, written once as control power is lost.
  always_ff @(posedge aclk)
  begin
    if (ce && power_fail && !pf_d)
    begin
      for (int i = 0; i < N; i++)
      begin
        nv_count[i] <= count[i];
        nv_frozen[i] <= frozen[i];
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pf_d <= 1'b0;
      nv_saved <= 1'b0;
    end
    else if (ce)
    begin
      pf_d <= power_fail;
      if (power_fail && !pf_d)
      begin
        nv_saved <= 1'b1;
      end
    end
  end

  // Write address and data are taken in either order; the response follows both.
  assign s_axi_awready = ce & ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ce & ~w_held & ~s_axi_bvalid;
  assign wr_go = aw_held & w_held & ~s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= eudc_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_mapped(aw_addr) ? eudc_pkg::RESP_OKAY : eudc_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Settings registers; preset is accepted at any time.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < N; i++)
      begin
        ctrl[i] <= eudc_pkg::CTRL_RST;
        preset[i] <= eudc_pkg::PRESET_RST;
        compare[i] <= eudc_pkg::COMPARE_RST;
      end
    end
    else if (ce && wr_go && addr_mapped(aw_addr))
    begin
      case (aw_addr[eudc_pkg::SEL_LSB-1:0])
        eudc_pkg::OFF_CTRL: ctrl[addr_sel(aw_addr)] <=
          byte_merge(ctrl[addr_sel(aw_addr)], w_data, w_strb);
        eudc_pkg::OFF_PRESET: preset[addr_sel(aw_addr)] <=
          byte_merge(preset[addr_sel(aw_addr)], w_data, w_strb);
        eudc_pkg::OFF_COMPARE: compare[addr_sel(aw_addr)] <=
          byte_merge(compare[addr_sel(aw_addr)], w_data, w_strb);
        default: ;
      endcase
    end
  end

  // Read decode.
  always_comb
  begin
    rd_word = eudc_pkg::ZERO_WORD;
    rd_ok = addr_mapped(s_axi_araddr);
    case (s_axi_araddr[eudc_pkg::SEL_LSB-1:0])
      eudc_pkg::OFF_CTRL: rd_word = ctrl[addr_sel(s_axi_araddr)];
      eudc_pkg::OFF_PRESET: rd_word = preset[addr_sel(s_axi_araddr)];
      eudc_pkg::OFF_COMPARE: rd_word = compare[addr_sel(s_axi_araddr)];
      eudc_pkg::OFF_COUNT: rd_word = count[addr_sel(s_axi_araddr)];
      eudc_pkg::OFF_FROZEN: rd_word = frozen[addr_sel(s_axi_araddr)];
      eudc_pkg::OFF_STAMP_LO: rd_word = stamp[addr_sel(s_axi_araddr)][31:0];
      eudc_pkg::OFF_STAMP_HI: rd_word = stamp[addr_sel(s_axi_araddr)][63:32];
      eudc_pkg::OFF_STATUS:
      begin
        rd_word[eudc_pkg::STAT_ABOVE_BIT] = count_above_flag[addr_sel(s_axi_araddr)];
        rd_word[eudc_pkg::STAT_EQUAL_BIT] = count_equal_flag[addr_sel(s_axi_araddr)];
        rd_word[eudc_pkg::STAT_BELOW_BIT] = count_below_flag[addr_sel(s_axi_araddr)];
        rd_word[eudc_pkg::STAT_BLOCKED_BIT] = count_block[addr_sel(s_axi_araddr)];
        rd_word[eudc_pkg::STAT_NV_BIT] = nv_saved;
      end
      eudc_pkg::OFF_NV_COUNT: rd_word = nv_count[addr_sel(s_axi_araddr)];
      eudc_pkg::OFF_NV_FROZEN: rd_word = nv_frozen[addr_sel(s_axi_araddr)];
      default: rd_ok = 1'b0;
    endcase
    if (!rd_ok)
    begin
      rd_word = eudc_pkg::ZERO_WORD;
    end
  end

  assign s_axi_arready = ce & ~s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= eudc_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? eudc_pkg::RESP_OKAY : eudc_pkg::RESP_SLVERR;
      end
      else if (s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  for (genvar g = 0; g < N; g++)
  begin : g_chk
    sequence s_quiet_run;
      ce && running[g] && !rst_rise[g] && !frr_rise[g] && !lps_rise[g] && !count_block[g];
    endsequence
    sequence s_freeze_go;
      ce && running[g] && frc_rise[g] && !rst_rise[g] && !frr_rise[g];
    endsequence
    a_up_wrap: assert property (s_quiet_run ##0 (up_rise[g] && !dn_rise[g]
      && count[g] == eudc_pkg::COUNT_MAX) |=> count[g] == eudc_pkg::COUNT_MIN)
      else $error("Up count did not wrap to the most negative value.");
    a_down_wrap: assert property (s_quiet_run ##0 (dn_rise[g] && !up_rise[g]
      && count[g] == eudc_pkg::COUNT_MIN) |=> count[g] == eudc_pkg::COUNT_MAX)
      else $error("Down count did not wrap to the largest positive value.");
    a_level_steady: assert property (s_quiet_run ##0 (!up_rise[g] && !dn_rise[g])
      |=> $stable(count[g]))
      else $error("Count changed without a rising edge.");
    a_block_hold: assert property (ce && count_block[g] |=> !count_above_flag[g]
      && !count_equal_flag[g] && !count_below_flag[g])
      else $error("Blocked counter drove an output flag.");
    a_enable_load: assert property (ce && en_rise[g] |=> count[g] ==
      ($past(load_preset_select[g]) ? $past(preset[g]) : eudc_pkg::ZERO_WORD))
      else $error("Enable did not load preset or zero.");
    a_preset_edge: assert property (ce && running[g] && !rst_rise[g] && !frr_rise[g]
      && lps_rise[g] |=> count[g] == $past(preset[g]))
      else $error("Rising preset select did not load preset.");
    a_reset_load: assert property (ce && running[g] && (rst_rise[g] || frr_rise[g]) |=>
      count[g] == ($past(load_preset_select[g]) ? $past(preset[g]) : eudc_pkg::ZERO_WORD))
      else $error("Reset did not load preset or zero.");
    a_freeze_clear: assert property (ce && running[g] && frr_rise[g] |=> frozen[g] ==
      $past(count[g]) && stamp[g] == $past(stamp_time))
      else $error("Freeze-reset did not capture count and stamp.");
    a_freeze_keep: assert property (s_freeze_go ##0 (!lps_rise[g] && !count_block[g]
      && !up_rise[g] && !dn_rise[g]) |=> frozen[g] == $past(count[g])
      && count[g] == $past(count[g]) && stamp[g] == $past(stamp_time))
      else $error("Freeze-continue disturbed the count or missed the capture.");
    a_flags_match: assert property (ce && en[g] && !count_block[g] |=> $onehot({
      count_above_flag[g], count_equal_flag[g], count_below_flag[g]}) && (count_equal_flag[g]
      == (count[g] == $signed($past(compare[g])))))
      else $error("Compare flags do not match the count.");
    a_nv_store: assert property (ce && power_fail && !pf_d |=> nv_count[g] ==
      $past(count[g]) && nv_frozen[g] == $past(frozen[g]) && nv_saved)
      else $error("Power loss did not save the counts.");
  end

endmodule

//--- tb/eudc_op_src.sv
`timescale 1ns/1ps
// Internal operand source: each strobe sets one operand bit of one counter to a level.
module eudc_op_src (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Operand request.
  input wire logic op_stb,
  input wire logic [2:0] op_sel,
  input wire logic [2:0] op_idx,
  input wire logic op_lvl,
  // Operands: up, down, block, preset select, reset, freeze-reset, freeze-count.
  output logic [6:0][7:0] op
);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      op <= '0;
    end
    else if (op_stb)
    begin
      op[op_sel][op_idx] <= op_lvl;
    end
  end
endmodule

//--- tb/eudc_counter_bank_tb.sv
`timescale 1ns/1ps
module eudc_counter_bank_tb;
  logic aclk = 0, aresetn = 0, ce = 1, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid, nv_saved;
  logic power_fail = 0, op_stb = 0, op_lvl = 0;
  logic [2:0] op_sel = 0, op_idx = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rd;
  logic [3:0] wstrb = 0;
  logic [1:0] bresp, rresp, rsp;
  logic [63:0] stamp_time = 0, st;
  logic [6:0][7:0] op;
  logic [7:0] f_hi, f_eq, f_lo;
  logic [31:0] cnt [8];
  logic [31:0] cmpv [8];
  int errors = 0, checks_done = 0, seed = 52380;

  initial
  begin
    forever #2 aclk = ~aclk;
  end

  eudc_op_src i_src (.aclk(aclk), .aresetn(aresetn), .op_stb(op_stb), .op_sel(op_sel),
    .op_idx(op_idx), .op_lvl(op_lvl), .op(op));

  eudc_counter_bank i_dut (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .count_up(op[0]), .count_down(op[1]), .count_block(op[2]),
    .load_preset_select(op[3]), .count_reset(op[4]), .freeze_reset(op[5]),
    .freeze_count(op[6]), .stamp_time(stamp_time), .power_fail(power_fail),
    .count_above_flag(f_hi), .count_equal_flag(f_eq), .count_below_flag(f_lo),
    .nv_saved(nv_saved)
  );

  task automatic final_report();
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    do
    begin
      @(negedge aclk);
      n++;
      if (n > 50)
      begin
        errors++;
        $display("[ERR] %0t bus wait ran out", $time);
        final_report();
      end
    end while (s !== 1'b1);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ta, tw;
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1;
    bready <= 1;
    ta = 0;
    tw = 0;
    // Stop as soon as both channels are taken, so the one-cycle response is not missed.
    while (!(ta && tw))
    begin
      @(negedge aclk);
      ta = ta || (awvalid && awready);
      tw = tw || (wvalid && wready);
      @(posedge aclk);
      if (ta)
        awvalid <= 0;
      if (tw)
        wvalid <= 0;
      n++;
      if (n > 50)
      begin
        errors++;
        $display("[ERR] %0t write channels not taken", $time);
        final_report();
      end
    end
    wait_hi(bvalid);
    rsp = bresp;
    @(posedge aclk);
    bready <= 0;
  endtask

  task automatic rd_reg(input logic [11:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    wait_hi(arready);
    @(posedge aclk);
    arvalid <= 0;
    wait_hi(rvalid);
    rd = rdata;
    rsp = rresp;
    @(posedge aclk);
    rready <= 0;
  endtask

  task automatic drive(input int s, input int k, input logic l);
    @(posedge aclk);
    op_sel <= 3'(s);
    op_idx <= 3'(k);
    op_lvl <= l;
    op_stb <= 1;
    @(posedge aclk);
    op_stb <= 0;
    repeat (2) @(posedge aclk);
  endtask

  task automatic pulse(input int s, input int k);
    drive(s, k, 1);
    drive(s, k, 0);
  endtask

  function automatic logic [11:0] ad(input int k, input logic [5:0] o);
    return {3'h0, 3'(k), o};
  endfunction

  function automatic logic [31:0] flg(input logic [31:0] c, input logic [31:0] m);
    return {29'h0000_0000, $signed(c) < $signed(m), c == m, $signed(c) > $signed(m)};
  endfunction

  task automatic ck(input int k);
    rd_reg(ad(k, eudc_pkg::OFF_COUNT));
    chk(rd, cnt[k]);
    chk({29'h0000_0000, f_lo[k], f_eq[k], f_hi[k]}, flg(cnt[k], cmpv[k]));
  endtask

  initial
  begin
    int k, s;
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    // Reset values, then enable with preset select low loads zero.
    for (k = 0; k < 8; k++)
    begin
      rd_reg(ad(k, eudc_pkg::OFF_CTRL));
      chk(rd, eudc_pkg::CTRL_RST);
      rd_reg(ad(k, eudc_pkg::OFF_PRESET));
      chk(rd, eudc_pkg::PRESET_RST);
      cnt[k] = 32'h0000_0000;
      cmpv[k] = 32'($random(seed) % 3);
      wr(ad(k, eudc_pkg::OFF_PRESET), 32'h0000_0055);
      wr(ad(k, eudc_pkg::OFF_COMPARE), cmpv[k]);
      wr(ad(k, eudc_pkg::OFF_CTRL), 32'h0000_0001);
      chk({30'h0000_0000, rsp}, {30'h0000_0000, eudc_pkg::RESP_OKAY});
      ck(k);
    end
    // Unmapped places answer with an error.
    rd_reg(12'h200);
    chk({30'h0000_0000, rsp}, {30'h0000_0000, eudc_pkg::RESP_SLVERR});
    rd_reg(ad(0, 6'h3c));
    chk({30'h0000_0000, rsp}, {30'h0000_0000, eudc_pkg::RESP_SLVERR});
    // Random up and down pulses spread over all counters.
    repeat (60)
    begin
      k = $random(seed) & 7;
      s = $random(seed) & 1;
      pulse(s, k);
      cnt[k] = s ? cnt[k] - eudc_pkg::COUNT_ONE : cnt[k] + eudc_pkg::COUNT_ONE;
      ck(k);
    end
    // Preset select while running, then wraparound at both limits.
    wr(ad(2, eudc_pkg::OFF_PRESET), eudc_pkg::COUNT_MAX);
    drive(3, 2, 1);
    cnt[2] = eudc_pkg::COUNT_MAX;
    ck(2);
    drive(3, 2, 0);
    ck(2);
    drive(3, 2, 1);
    pulse(0, 2);
    cnt[2] = eudc_pkg::COUNT_MIN;
    ck(2);
    pulse(1, 2);
    cnt[2] = eudc_pkg::COUNT_MAX;
    ck(2);
    // Reset command and re-enable load the preset while select is high.
    pulse(1, 2);
    pulse(4, 2);
    ck(2);
    pulse(1, 2);
    wr(ad(2, eudc_pkg::OFF_CTRL), 32'h0000_0000);
    wr(ad(2, eudc_pkg::OFF_CTRL), 32'h0000_0001);
    ck(2);
    // Block stops counting and holds the flags low.
    drive(2, 2, 1);
    pulse(0, 2);
    rd_reg(ad(2, eudc_pkg::OFF_COUNT));
    chk(rd, cnt[2]);
    chk({29'h0000_0000, f_lo[2], f_eq[2], f_hi[2]}, 32'h0000_0000);
    drive(2, 2, 0);
    // Freeze-count keeps counting; freeze-reset with select low clears.
    st = {$random(seed), $random(seed)};
    stamp_time <= st;
    pulse(6, 2);
    rd_reg(ad(2, eudc_pkg::OFF_FROZEN));
    chk(rd, cnt[2]);
    rd_reg(ad(2, eudc_pkg::OFF_STAMP_LO));
    chk(rd, st[31:0]);
    rd_reg(ad(2, eudc_pkg::OFF_STAMP_HI));
    chk(rd, st[63:32]);
    pulse(0, 2);
    cnt[2] = eudc_pkg::COUNT_MIN;
    ck(2);
    drive(3, 2, 0);
    pulse(5, 2);
    rd_reg(ad(2, eudc_pkg::OFF_FROZEN));
    chk(rd, eudc_pkg::COUNT_MIN);
    cnt[2] = eudc_pkg::ZERO_WORD;
    ck(2);
    // Power loss saves both counts.
    @(posedge aclk);
    power_fail <= 1;
    repeat (3) @(posedge aclk);
    chk({31'h0000_0000, nv_saved}, 32'h0000_0001);
    rd_reg(ad(2, eudc_pkg::OFF_NV_COUNT));
    chk(rd, eudc_pkg::ZERO_WORD);
    rd_reg(ad(2, eudc_pkg::OFF_NV_FROZEN));
    chk(rd, eudc_pkg::COUNT_MIN);
    final_report();
  end
endmodule
